// file: verilog/rsc_defines.svh
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

`define RSC_AW                16
`define RSC_DW                16
`define RSC_MVW               12

// Register addresses
`define RSC_ADDR_REGA_SLEEP   16'h4082
`define RSC_ADDR_REGB_CTRL    16'h4083
`define RSC_ADDR_REGB_ON      16'h4084
`define RSC_ADDR_REGB_SLEEP   16'h4085
`define RSC_ADDR_STATUS       16'h40f0

// Field positions
`define RSC_F_ACT             15:14
`define RSC_F_SRC             12:11
`define RSC_F_VPICK           10
`define RSC_F_HMODE           9:8
`define RSC_F_FLOAT           7
`define RSC_F_SWITCH          6
`define RSC_F_SLOT            15:13
`define RSC_F_MODE            8
`define RSC_F_VOLT            4:0
`define RSC_F_ST_PWR          1:0
`define RSC_F_ST_FAULT        2
`define RSC_F_ST_EN           3
`define RSC_F_ST_HWC          4

// Reset values
`define RSC_RST_HMODE         2'h2
`define RSC_RST_ON_MODE       1'h0
`define RSC_RST_SLP_MODE      1'h1

// Field codes
`define RSC_ACT_REG_OFF       2'h1
`define RSC_ACT_SYS_RST       2'h2
`define RSC_SRC_HWC1          2'h1
`define RSC_SRC_HWC2          2'h2
`define RSC_SRC_EITHER        2'h3
`define RSC_HMODE_OFF         2'h1
`define RSC_HMODE_ON_MODE     2'h3
`define RSC_SLOT_NONE         3'h0
`define RSC_SLOT_LAST_TIMED   3'h5
`define RSC_SLOT_HWE1         3'h6
`define RSC_SLOT_HWE2         3'h7
`define RSC_SLP_REV_BASE      3'h6
`define RSC_TS5               3'h5
`define RSC_TS3               3'h3
`define RSC_TS1               3'h1

// Voltage map
`define RSC_CODE_KNEE         5'h0c
`define RSC_CODE_COARSE       5'h0d
`define RSC_CODE_MAX          5'h1f
`define RSC_MV_BASE           12'h3e8
`define RSC_MV_FINE_STEP      12'h032
`define RSC_MV_KNEE           12'h640
`define RSC_MV_COARSE_BASE    12'h6a4
`define RSC_MV_COARSE_STEP    12'h064
`define RSC_MV_MAX            12'hdac

`endif

// file: verilog/rsc_pkg.sv
package rsc_pkg;

    typedef enum logic [1:0] {
        RSC_PWR_OFF,
        RSC_PWR_ON,
        RSC_PWR_SLEEP
    } rsc_pwr_t;

    typedef struct packed {
        logic [4:0]  rega_sleep_voltage;
        logic [1:0]  regb_fault_action;
        logic [1:0]  regb_hw_ctrl_source;
        logic        regb_hw_ctrl_voltage_pick;
        logic [1:0]  regb_hw_ctrl_mode;
        logic        regb_output_float;
        logic        regb_switch_mode;
        logic [2:0]  regb_on_slot;
        logic        regb_on_mode;
        logic [4:0]  regb_on_voltage;
        logic [2:0]  regb_sleep_slot;
        logic        regb_sleep_mode;
        logic [4:0]  regb_sleep_voltage;
        rsc_pwr_t    pwr;
        logic        fault_off;
        logic        hwc_active;
        logic [15:0] rdata;
        logic        enable;
        logic        low_power;
        logic [4:0]  vcode;
        logic [11:0] regb_mv;
        logic [11:0] rega_mv;
        logic        fault_irq;
        logic        sys_reset_req;
    } rsc_state_t;

endpackage

// file: verilog/rsc_volt_if.sv
interface rsc_volt_if;
    logic [4:0]  code_a;
    logic [4:0]  code_b;
    logic [11:0] mv_a;
    logic [11:0] mv_b;

    modport client (output code_a, output code_b, input mv_a, input mv_b);
    modport mapper (input code_a, input code_b, output mv_a, output mv_b);
endinterface

// file: verilog/rsc_volt_map.sv
`include "rsc_defines.svh"

module rsc_volt_map (
    // Codes in, millivolts out
    rsc_volt_if.mapper vif
);

    // Two linear segments; the coarse one skips 1.65 V
    function automatic logic [11:0] code_to_mv(input logic [4:0] code);
        logic [11:0] c;
        c = {7'h00, code};
        if (code <= `RSC_CODE_KNEE)
            code_to_mv = 12'(`RSC_MV_BASE + c * `RSC_MV_FINE_STEP); // [R1]
        else
            code_to_mv = 12'(`RSC_MV_COARSE_BASE
                + (c - {7'h00, `RSC_CODE_COARSE}) * `RSC_MV_COARSE_STEP);
    endfunction

    assign vif.mv_a = code_to_mv(vif.code_a);
    assign vif.mv_b = code_to_mv(vif.code_b);

endmodule // rsc_volt_map

// file: verilog/rsc_regb_ctrl.sv
`include "rsc_defines.svh"

// Function
// [R1] Each 5-bit voltage code maps 00h to 1.00 V, 50 mV steps to 1.60 V at 0Ch, then 100 mV steps from 1.70 V at 0Dh to 3.50 V at 1Fh.
// [R2] An undervoltage fault of regulator B is ignored, shuts the regulator down, or requests a device reset, per the 2-bit fault action field.
// [R3] Every undervoltage fault of regulator B raises an interrupt whatever the fault action.
// [R4] The hardware control source field picks none, input 1, input 2, or either input as the hardware control request.
// [R5] Under hardware control, the voltage pick bit selects the on voltage (0) or the sleep voltage (1).
// [R6] Under hardware control, mode codes 00 and 10 give low power, 01 turns the regulator off, 11 follows the on mode bit; reset value 10.
// [R7] The float bit chooses discharge (0) or float (1) when disabled, and the switch bit chooses switch mode (1) over regulating mode (0).
// [R8] On-slot code 000 never enables regulator B and codes 001 to 101 enable it in timeslots 1 to 5.
// [R9] On-slot codes 110 and 111 hand the enable to hardware enable input 1 or 2.
// [R10] The on mode bit picks normal (0) or low power (1) in the on state and resets to 0.
// [R11] Sleep-slot codes 001 to 101 disable regulator B on sleep entry in timeslots 5 down to 1.
// [R12] Sleep-slot codes 000, 110 and 111 keep regulator B on at sleep voltage and mode, in timeslots 5, 3 and 1.
// [R13] With a hardware enable assigned, sleep-slot codes 001 to 101 instead pick the timeslot of the sleep condition.
// [R14] The sleep mode bit picks normal (0) or low power (1) in the sleep state and resets to 1.
// [R15] After reset both slot fields read 000 and all voltage fields 00h.
// [R16] After reset fault action, control source, voltage pick, float and switch bits read 0.
// [R17] Fault action code 11 behaves as ignore while still raising the interrupt.
module rsc_regb_ctrl (
    // Clock and reset
    input  wire logic                clk_in,
    input  wire logic                reset_in,
    // Register port
    input  wire logic [`RSC_AW-1:0]  addr_in,
    input  wire logic [`RSC_DW-1:0]  wdata_in,
    input  wire logic                wr_in,
    input  wire logic                rd_in,
    output logic      [`RSC_DW-1:0]  rdata_out,
    // Hardware control and enable inputs
    input  wire logic                hw_ctrl1_in,
    input  wire logic                hw_ctrl2_in,
    input  wire logic                hw_enable1_in,
    input  wire logic                hw_enable2_in,
    // Sequencer
    input  wire logic [2:0]          seq_slot_in,
    input  wire logic                seq_up_stb_in,
    input  wire logic                seq_sleep_stb_in,
    // Fault detector
    input  wire logic                uv_fault_in,
    // Regulator B drive
    output logic                     regb_enable_out,
    output logic                     regb_low_power_out,
    output logic      [4:0]          regb_voltage_code_out,
    output logic      [`RSC_MVW-1:0] regb_millivolts_out,
    output logic                     regb_output_float_out,
    output logic                     regb_switch_mode_out,
    // Regulator A sleep target
    output logic      [`RSC_MVW-1:0] rega_sleep_millivolts_out,
    // Fault reporting
    output logic                     fault_irq_out,
    output logic                     system_reset_req_out
);

    rsc_pkg::rsc_state_t st_reg;
    rsc_pkg::rsc_state_t st_next;
    logic                hw_assigned;
    logic                hwe_level;
    logic                sleep_hit;
    logic                hwc_off;

    rsc_volt_if vif ();

    rsc_volt_map u_map (
        .vif (vif.mapper)
    );

    // Millivolts lag the code by one cycle; cheaper than a comb loop
    assign vif.code_a = st_reg.rega_sleep_voltage;
    assign vif.code_b = st_reg.vcode;

    function automatic logic hwc_request(input logic [1:0] src,
                                         input logic       c1,
                                         input logic       c2);
        case (src)
            `RSC_SRC_HWC1:   hwc_request = c1;
            `RSC_SRC_HWC2:   hwc_request = c2;
            `RSC_SRC_EITHER: hwc_request = c1 | c2;
            default:         hwc_request = 1'b0;
        endcase
    endfunction

    function automatic logic [2:0] sleep_ts(input logic [2:0] code);
        case (code)
            3'h0:    sleep_ts = `RSC_TS5;
            3'h6:    sleep_ts = `RSC_TS3;
            3'h7:    sleep_ts = `RSC_TS1;
            default: sleep_ts = 3'(`RSC_SLP_REV_BASE - code);
        endcase
    endfunction

    function automatic logic is_timed(input logic [2:0] code);
        is_timed = code != `RSC_SLOT_NONE && code <= `RSC_SLOT_LAST_TIMED;
    endfunction

    always_comb begin
        st_next = st_reg;
        hw_assigned = st_reg.regb_on_slot == `RSC_SLOT_HWE1
                   || st_reg.regb_on_slot == `RSC_SLOT_HWE2;
        hwe_level = st_reg.regb_on_slot == `RSC_SLOT_HWE1 ? hw_enable1_in
                                                          : hw_enable2_in;
        sleep_hit = seq_sleep_stb_in
                 && seq_slot_in == sleep_ts(st_reg.regb_sleep_slot);

        if (wr_in) begin
            case (addr_in)
                `RSC_ADDR_REGA_SLEEP: begin
                    st_next.rega_sleep_voltage = wdata_in[`RSC_F_VOLT];
                end
                `RSC_ADDR_REGB_CTRL: begin
                    st_next.regb_fault_action = wdata_in[`RSC_F_ACT];
                    st_next.regb_hw_ctrl_source = wdata_in[`RSC_F_SRC];
                    st_next.regb_hw_ctrl_voltage_pick = wdata_in[`RSC_F_VPICK];
                    st_next.regb_hw_ctrl_mode = wdata_in[`RSC_F_HMODE];
                    st_next.regb_output_float = wdata_in[`RSC_F_FLOAT];
                    st_next.regb_switch_mode = wdata_in[`RSC_F_SWITCH];
                    st_next.fault_off = 1'b0;
                end
                `RSC_ADDR_REGB_ON: begin
                    st_next.regb_on_slot = wdata_in[`RSC_F_SLOT];
                    st_next.regb_on_mode = wdata_in[`RSC_F_MODE];
                    st_next.regb_on_voltage = wdata_in[`RSC_F_VOLT];
                end
                `RSC_ADDR_REGB_SLEEP: begin
                    st_next.regb_sleep_slot = wdata_in[`RSC_F_SLOT];
                    st_next.regb_sleep_mode = wdata_in[`RSC_F_MODE];
                    st_next.regb_sleep_voltage = wdata_in[`RSC_F_VOLT];
                end
                default: begin
                end
            endcase
        end

        // Codes 00 and 11 fall through with no action
        st_next.fault_irq = uv_fault_in; // [R3]
        st_next.sys_reset_req = uv_fault_in
            && st_reg.regb_fault_action == `RSC_ACT_SYS_RST; // [R2] [R17]
        // Fault latch set wins over the clearing write
        if (uv_fault_in && st_reg.regb_fault_action == `RSC_ACT_REG_OFF)
            st_next.fault_off = 1'b1; // [R2]

        if (hw_assigned) begin
            if (!hwe_level) // [R9]
                st_next.pwr = rsc_pkg::RSC_PWR_OFF;
            else if (st_reg.pwr == rsc_pkg::RSC_PWR_OFF)
                st_next.pwr = rsc_pkg::RSC_PWR_ON;
            else if (st_reg.pwr == rsc_pkg::RSC_PWR_ON && sleep_hit)
                st_next.pwr = rsc_pkg::RSC_PWR_SLEEP; // [R13]
        end else begin
            case (st_reg.pwr)
                rsc_pkg::RSC_PWR_OFF: begin
                    if (seq_up_stb_in && is_timed(st_reg.regb_on_slot)
                        && seq_slot_in == st_reg.regb_on_slot)
                        st_next.pwr = rsc_pkg::RSC_PWR_ON; // [R8]
                end
                rsc_pkg::RSC_PWR_ON: begin
                    if (sleep_hit) begin
                        if (is_timed(st_reg.regb_sleep_slot))
                            st_next.pwr = rsc_pkg::RSC_PWR_OFF; // [R11]
                        else
                            st_next.pwr = rsc_pkg::RSC_PWR_SLEEP; // [R12]
                    end
                end
                rsc_pkg::RSC_PWR_SLEEP: begin
                    if (seq_up_stb_in && seq_slot_in == st_reg.regb_on_slot)
                        st_next.pwr = rsc_pkg::RSC_PWR_ON;
                end
                default: st_next.pwr = rsc_pkg::RSC_PWR_OFF;
            endcase
        end

        st_next.hwc_active = hwc_request(st_next.regb_hw_ctrl_source,
                                         hw_ctrl1_in, hw_ctrl2_in); // [R4]
        hwc_off = st_next.hwc_active
               && st_next.regb_hw_ctrl_mode == `RSC_HMODE_OFF; // [R6]
        st_next.enable = st_next.pwr != rsc_pkg::RSC_PWR_OFF
                      && !st_next.fault_off && !hwc_off;

        if (st_next.hwc_active) begin
            st_next.vcode = st_next.regb_hw_ctrl_voltage_pick
                          ? st_next.regb_sleep_voltage
                          : st_next.regb_on_voltage; // [R5]
            st_next.low_power =
                st_next.regb_hw_ctrl_mode == `RSC_HMODE_ON_MODE
                ? st_next.regb_on_mode : 1'b1; // [R6]
        end else if (st_next.pwr == rsc_pkg::RSC_PWR_SLEEP) begin
            st_next.vcode = st_next.regb_sleep_voltage;
            st_next.low_power = st_next.regb_sleep_mode; // [R14] [R12]
        end else begin
            st_next.vcode = st_next.regb_on_voltage;
            st_next.low_power = st_next.regb_on_mode; // [R10]
        end

        st_next.regb_mv = vif.mv_b; // [R1]
        st_next.rega_mv = vif.mv_a;

        // Read data stand for exactly the cycle after the strobe
        st_next.rdata = '0;
        if (rd_in) begin
            case (addr_in)
                `RSC_ADDR_REGA_SLEEP:
                    st_next.rdata[`RSC_F_VOLT] = st_reg.rega_sleep_voltage;
                `RSC_ADDR_REGB_CTRL: begin
                    st_next.rdata[`RSC_F_ACT] = st_reg.regb_fault_action;
                    st_next.rdata[`RSC_F_SRC] = st_reg.regb_hw_ctrl_source;
                    st_next.rdata[`RSC_F_VPICK] =
                        st_reg.regb_hw_ctrl_voltage_pick;
                    st_next.rdata[`RSC_F_HMODE] = st_reg.regb_hw_ctrl_mode;
                    st_next.rdata[`RSC_F_FLOAT] = st_reg.regb_output_float;
                    st_next.rdata[`RSC_F_SWITCH] = st_reg.regb_switch_mode;
                end
                `RSC_ADDR_REGB_ON: begin
                    st_next.rdata[`RSC_F_SLOT] = st_reg.regb_on_slot;
                    st_next.rdata[`RSC_F_MODE] = st_reg.regb_on_mode;
                    st_next.rdata[`RSC_F_VOLT] = st_reg.regb_on_voltage;
                end
                `RSC_ADDR_REGB_SLEEP: begin
                    st_next.rdata[`RSC_F_SLOT] = st_reg.regb_sleep_slot;
                    st_next.rdata[`RSC_F_MODE] = st_reg.regb_sleep_mode;
                    st_next.rdata[`RSC_F_VOLT] = st_reg.regb_sleep_voltage;
                end
                `RSC_ADDR_STATUS: begin
                    st_next.rdata[`RSC_F_ST_PWR] = st_reg.pwr;
                    st_next.rdata[`RSC_F_ST_FAULT] = st_reg.fault_off;
                    st_next.rdata[`RSC_F_ST_EN] = st_reg.enable;
                    st_next.rdata[`RSC_F_ST_HWC] = st_reg.hwc_active;
                end
                default: st_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_reg <= '0; // [R15] [R16]
            st_reg.regb_hw_ctrl_mode <= `RSC_RST_HMODE; // [R6]
            st_reg.regb_on_mode <= `RSC_RST_ON_MODE; // [R10]
            st_reg.regb_sleep_mode <= `RSC_RST_SLP_MODE; // [R14]
            st_reg.pwr <= rsc_pkg::RSC_PWR_OFF;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_out                 = st_reg.rdata;
    assign regb_enable_out           = st_reg.enable;
    assign regb_low_power_out        = st_reg.low_power;
    assign regb_voltage_code_out     = st_reg.vcode;
    assign regb_millivolts_out       = st_reg.regb_mv;
    assign regb_output_float_out     = st_reg.regb_output_float; // [R7]
    assign regb_switch_mode_out      = st_reg.regb_switch_mode; // [R7]
    assign rega_sleep_millivolts_out = st_reg.rega_mv;
    assign fault_irq_out             = st_reg.fault_irq;
    assign system_reset_req_out      = st_reg.sys_reset_req;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    property p_volt_map;
        (regb_voltage_code_out == `RSC_CODE_KNEE |=>
            regb_millivolts_out == `RSC_MV_KNEE)
        and (regb_voltage_code_out == `RSC_CODE_MAX |=>
            regb_millivolts_out == `RSC_MV_MAX);
    endproperty
    a_volt_map: assert property (p_volt_map) // [R1]
        else $error("voltage code to millivolt map wrong");

    property p_irq_always;
        uv_fault_in |=> fault_irq_out ##1 !fault_irq_out || $past(uv_fault_in);
    endproperty
    a_irq_always: assert property (p_irq_always) // [R3]
        else $error("fault did not raise a one-cycle interrupt");

    property p_reg_off;
        uv_fault_in && st_reg.regb_fault_action == `RSC_ACT_REG_OFF
            |=> !regb_enable_out && st_reg.fault_off;
    endproperty
    a_reg_off: assert property (p_reg_off) // [R2]
        else $error("regulator not shut down on fault");

    property p_sys_reset;
        uv_fault_in |=> system_reset_req_out ==
            ($past(st_reg.regb_fault_action) == `RSC_ACT_SYS_RST);
    endproperty
    a_sys_reset: assert property (p_sys_reset) // [R2]
        else $error("device reset request does not match fault action");

    property p_reserved_ignore;
        uv_fault_in && st_reg.regb_fault_action == 2'h3 && !st_reg.fault_off
            |=> !st_reg.fault_off && !system_reset_req_out;
    endproperty
    a_reserved_ignore: assert property (p_reserved_ignore) // [R17]
        else $error("reserved fault action shut something down");

    property p_reset_values;
        @(posedge clk_in) disable iff (1'b0)
        $fell(reset_in) |-> st_reg.regb_on_slot == 3'h0
            && st_reg.regb_sleep_slot == 3'h0 && st_reg.regb_on_voltage == 5'h00
            && st_reg.regb_sleep_voltage == 5'h00
            && st_reg.rega_sleep_voltage == 5'h00;
    endproperty
    a_reset_values: assert property (p_reset_values) // [R15]
        else $error("slot or voltage field not reset");

    property p_ctrl_reset;
        @(posedge clk_in) disable iff (1'b0)
        $fell(reset_in) |-> st_reg.regb_fault_action == 2'h0
            && st_reg.regb_hw_ctrl_source == 2'h0
            && st_reg.regb_hw_ctrl_mode == 2'h2 && !st_reg.regb_on_mode
            && st_reg.regb_sleep_mode && !regb_output_float_out
            && !regb_switch_mode_out && !st_reg.regb_hw_ctrl_voltage_pick;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) // [R16]
        else $error("control field not reset");

    property p_hw_pick;
        st_reg.hwc_active && !wr_in && st_reg.regb_hw_ctrl_voltage_pick
            && $stable(st_reg.hwc_active) ##1 st_reg.hwc_active
            |-> regb_voltage_code_out == st_reg.regb_sleep_voltage;
    endproperty
    a_hw_pick: assert property (p_hw_pick) // [R5]
        else $error("hardware control voltage pick ignored");

    property p_hw_enable;
        hw_assigned && !wr_in && !uv_fault_in && !st_reg.fault_off
            && !st_reg.regb_hw_ctrl_source[0] && !st_reg.regb_hw_ctrl_source[1]
            |=> regb_enable_out == $past(hwe_level);
    endproperty
    a_hw_enable: assert property (p_hw_enable) // [R9]
        else $error("hardware enable input not followed");

    property p_sleep_disable;
        !hw_assigned && st_reg.pwr == rsc_pkg::RSC_PWR_ON && sleep_hit
            && is_timed(st_reg.regb_sleep_slot) |=> !regb_enable_out;
    endproperty
    a_sleep_disable: assert property (p_sleep_disable) // [R11]
        else $error("regulator not disabled at its sleep slot");

    c_fault: cover property (uv_fault_in ##1 fault_irq_out);
    c_sleep: cover property (st_reg.pwr == rsc_pkg::RSC_PWR_SLEEP);
    c_hwc: cover property (st_reg.hwc_active && regb_enable_out);

endmodule // rsc_regb_ctrl

// file: verification/rsc_regb_ctrl_tb.sv
`include "rsc_defines.svh"

module rsc_regb_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in   = 1'b0;
    logic        reset_in = 1'b1;
    logic [15:0] addr_in  = 16'h0000;
    logic [15:0] wdata_in = 16'h0000;
    logic        wr_in    = 1'b0;
    logic        rd_in    = 1'b0;
    logic [3:0]  hw_in    = 4'h0;
    logic [2:0]  slot_in  = 3'h0;
    logic        up_in    = 1'b0;
    logic        slp_in   = 1'b0;
    logic        uv_in    = 1'b0;
    logic [15:0] rdata;
    logic        en;
    logic        lp;
    logic        flt;
    logic        sw;
    logic        irq;
    logic        srq;
    logic [4:0]  vc;
    logic [11:0] mva;
    logic [11:0] mvb;
    int          failures = 0;
    int          n_checks = 0;
    int          seed     = 1;
    int          s;
    int          t;
    int          act;

    rsc_regb_ctrl rsc_regb_ctrl_i (
        .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata), .hw_ctrl1_in(hw_in[0]), .hw_ctrl2_in(hw_in[1]),
        .hw_enable1_in(hw_in[2]), .hw_enable2_in(hw_in[3]),
        .seq_slot_in(slot_in), .seq_up_stb_in(up_in),
        .seq_sleep_stb_in(slp_in), .uv_fault_in(uv_in),
        .regb_enable_out(en), .regb_low_power_out(lp),
        .regb_voltage_code_out(vc), .regb_millivolts_out(mvb),
        .regb_output_float_out(flt), .regb_switch_mode_out(sw),
        .rega_sleep_millivolts_out(mva), .fault_irq_out(irq),
        .system_reset_req_out(srq));

    always #4 clk_in = ~clk_in;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    // Sequencer strobe; outputs except the millivolts (one cycle later) are settled when this returns
    task automatic seq(input logic up, input logic [2:0] slot);
        @(posedge clk_in);
        slot_in <= slot;
        up_in   <= up;
        slp_in  <= !up;
        @(posedge clk_in);
        up_in   <= 1'b0;
        slp_in  <= 1'b0;
        #1;
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        rd_chk(`RSC_ADDR_REGA_SLEEP, 16'h0000);
        rd_chk(`RSC_ADDR_REGB_CTRL, 16'h0200);
        rd_chk(`RSC_ADDR_REGB_ON, 16'h0000);
        rd_chk(`RSC_ADDR_REGB_SLEEP, 16'h0100);
        rd_chk(16'h4086, 16'h0000);
        for (int c = 0; c < 32; c++) begin
            wr(`RSC_ADDR_REGA_SLEEP, 16'(c));
            wr(`RSC_ADDR_REGB_ON, 16'(c));
            repeat (2) @(posedge clk_in);
            #1 chk(mva, 16'(c <= 12 ? 1000 + 50 * c : 1700 + 100 * (c - 13)));
            chk(mvb, 16'(c <= 12 ? 1000 + 50 * c : 1700 + 100 * (c - 13)));
            rd_chk(`RSC_ADDR_REGA_SLEEP, 16'(c));
        end
        // Every sleep code, with a random on slot each time
        for (int c = 0; c < 8; c++) begin
            s = 1 + ($unsigned($random(seed)) % 5);
            wr(`RSC_ADDR_REGB_ON, 16'(s << 13));
            wr(`RSC_ADDR_REGB_SLEEP, 16'((c << 13) | 16'h0100));
            seq(1'b1, 3'(s));
            chk(16'({en, lp}), 16'h0002);
            t = (c >= 1 && c <= 5) ? 6 - c : (c == 0 ? 5 : (c == 6 ? 3 : 1));
            seq(1'b0, 3'(t == 5 ? 4 : t + 1));
            chk(16'(en), 16'h0001);
            seq(1'b0, 3'(t));
            chk(16'({en, lp}), (c >= 1 && c <= 5) ? 16'h0000 : 16'h0003);
        end
        // Hardware enable inputs 1 and 2 take over the enable
        for (int k = 0; k < 2; k++) begin
            wr(`RSC_ADDR_REGB_ON, 16'((6 + k) << 13));
            wr(`RSC_ADDR_REGB_SLEEP, 16'h4100);
            @(posedge clk_in);
            hw_in <= 4'(4 << k);
            repeat (2) @(posedge clk_in);
            #1 chk(16'(en), 16'h0001);
            @(posedge clk_in);
            hw_in <= 4'h0;
            repeat (2) @(posedge clk_in);
            #1 chk(16'(en), 16'h0000);
            @(posedge clk_in);
            hw_in <= 4'(4 << k);
            seq(1'b0, 3'h4);
            @(posedge clk_in);
            #1 chk(16'({en, lp}), 16'h0003);
        end
        @(posedge clk_in);
        hw_in <= 4'h0;
        wr(`RSC_ADDR_REGB_ON, 16'h2103);
        wr(`RSC_ADDR_REGB_SLEEP, 16'h211f);
        seq(1'b1, 3'h1);
        for (int src = 1; src < 4; src++) begin
            @(posedge clk_in);
            hw_in <= 4'($unsigned($random(seed)) % 4);
            wr(`RSC_ADDR_REGB_CTRL, 16'((src << 11) | 16'h07c0));
            act = (src & hw_in) != 0;
            @(posedge clk_in);
            #1 chk(16'(vc), act ? 16'h001f : 16'h0003);
            chk(16'({flt, sw, lp}), 16'h0007);
            wr(`RSC_ADDR_REGB_CTRL, 16'((src << 11) | 16'h0500));
            @(posedge clk_in);
            #1 chk(16'(en), 16'(!act));
        end
        @(posedge clk_in);
        hw_in <= 4'h0;
        for (int a = 0; a < 4; a++) begin
            wr(`RSC_ADDR_REGB_CTRL, 16'(a << 14));
            @(posedge clk_in);
            uv_in <= 1'b1;
            @(posedge clk_in);
            uv_in <= 1'b0;
            #1 chk(16'({irq, srq, en}), 16'({1'b1, a == 2, a != 1}));
            @(posedge clk_in);
            #1 chk(16'(irq), 16'h0000);
        end
        close_out();
    end
endmodule // rsc_regb_ctrl_tb
